// file: common/lsp_pkg.sv
`default_nettype none
package lsp_pkg;
  // Pin counts and the index of each pin group in the flat pin vector.
  localparam int unsigned LSP_NPRI = 7;
  localparam int unsigned LSP_NPIN = 14;
  localparam int unsigned LSP_PIN_PRI = 0;
  localparam int unsigned LSP_PIN_LOW = 7;
  localparam int unsigned LSP_PIN_P3 = 9;
  localparam int unsigned LSP_PIN_UP = 10;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] LSP_CTRL_OFF = 8'h00;
  localparam logic [7:0] LSP_LEDON_OFF = 8'h04;
  localparam logic [7:0] LSP_STRAP_OFF = 8'h08;
  localparam logic [7:0] LSP_PININ_OFF = 8'h0c;

  // Control register fields and reset values.
  localparam int unsigned LSP_CTRL_LEDEN = 0;
  localparam logic LSP_CTRL_RST = 1'b0;
  localparam logic [13:0] LSP_LEDON_RST = 14'h0000;

  // Strap status register fields.
  localparam int unsigned LSP_ST_SWAP = 0;
  localparam int unsigned LSP_ST_GANG = 7;
  localparam int unsigned LSP_ST_BOOST = 8;
  localparam int unsigned LSP_ST_DONE = 10;

  // Values taken when a strap is not enabled.
  localparam logic [6:0] LSP_SWAP_DFLT = 7'h00;
  localparam logic LSP_GANG_DFLT = 1'b0;
  localparam logic [1:0] LSP_BOOST_DFLT = 2'h0;
  localparam logic LSP_ACTLOW_DFLT = 1'b1;

  // AHB-Lite encodings.
  localparam logic [1:0] LSP_HTRANS_NONSEQ = 2'h2;
  localparam logic LSP_HRESP_OKAY = 1'b0;

  // Strap capture phase, Gray coded.
  typedef enum logic {
    LSP_SAMPLE = 1'b0,
    LSP_RUN = 1'b1
  } lsp_phase_e;
endpackage : lsp_pkg
`default_nettype wire

// file: common/lsp_pin_if.sv
`default_nettype none
interface lsp_pin_if;
  import lsp_pkg::*;
  logic run;
  logic ledEnable;
  logic [13:0] ledOn;
  logic [13:0] activeLow;
  logic [13:0] pinOut;
  logic [13:0] pinOe;
  // The controller decides, the driver owns the pin flops.
  modport ctrl (output run, output ledEnable, output ledOn, output activeLow,
    input pinOut, input pinOe);
  modport drv (input run, input ledEnable, input ledOn, input activeLow,
    output pinOut, output pinOe);
endinterface : lsp_pin_if
`default_nettype wire

// file: hw/lsp_pin_drive.sv
`default_nettype none
module lsp_pin_drive
  import lsp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pin requests and registered pin drive.
  lsp_pin_if.drv pins
);
  logic [13:0] next_pinOut;
  logic [13:0] next_pinOe;

  // Each pin turns the logical lamp state into a level by its own polarity.
  // Drivers stay off until the straps are taken so that pull resistors set the level.
  for (genvar i = 0; i < LSP_NPIN; i++) begin : g_pin
    always_comb begin
      next_pinOut[i] = pins.activeLow[i] ? ~pins.ledOn[i] : pins.ledOn[i];
      next_pinOe[i] = pins.run & pins.ledEnable;
    end
  end

  // Pin flops; reset leaves every pin released.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.pinOut <= 14'h0000;
      pins.pinOe <= 14'h0000;
    end else begin
      pins.pinOut <= next_pinOut;
      pins.pinOe <= next_pinOe;
    end
  end
endmodule : lsp_pin_drive
`default_nettype wire

// file: hw/led_strap_pin_logic.sv
// Local design decisions: the AHB-Lite register port and the register offsets.
`default_nettype none
module led_strap_pin_logic
  import lsp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Strap enables from package and configuration settings.
  input wire logic swapStrapEnable,
  input wire logic gangStrapEnable,
  input wire logic boostStrapEnable,
  // Primary lamp pins, ports one to seven.
  input wire logic [6:0] portPrimaryLedIn,
  output logic [6:0] portPrimaryLedOut,
  output logic [6:0] portPrimaryLedOe,
  // Secondary lamp pins, ports four to seven.
  input wire logic [3:0] upperPortSecondaryLedIn,
  output logic [3:0] upperPortSecondaryLedOut,
  output logic [3:0] upperPortSecondaryLedOe,
  // Secondary lamp pin, port three.
  input wire logic port3SecondaryLedIn,
  output logic port3SecondaryLedOut,
  output logic port3SecondaryLedOe,
  // Secondary lamp pins, ports one and two.
  input wire logic [1:0] lowPortSecondaryLedIn,
  output logic [1:0] lowPortSecondaryLedOut,
  output logic [1:0] lowPortSecondaryLedOe,
  // Configuration taken from the straps.
  output logic [6:0] portPolaritySwap,
  output logic gangPowerMode,
  output logic [1:0] phyDriveLevelField
);
  lsp_pin_if pins ();

  // Capture phase.
  lsp_phase_e phase;
  lsp_phase_e next_phase;

  // Latched straps and lamp polarities.
  logic [6:0] next_portPolaritySwap;
  logic next_gangPowerMode;
  logic [1:0] next_phyDriveLevelField;
  logic [13:0] activeLow;
  logic [13:0] next_activeLow;

  // Software state.
  logic ledEnable;
  logic next_ledEnable;
  logic [13:0] ledOn;
  logic [13:0] next_ledOn;

  // Bus pipeline state.
  logic wrPending;
  logic next_wrPending;
  logic [7:0] wrAddr;
  logic [7:0] next_wrAddr;
  logic [31:0] next_hrdata;
  logic addrPhase;
  logic [13:0] pinIn;
  logic [31:0] ctrlView;
  logic [31:0] ledOnView;

  // Flat view of every lamp pin as seen from outside.
  always_comb begin
    pinIn = {upperPortSecondaryLedIn, port3SecondaryLedIn,
      lowPortSecondaryLedIn, portPrimaryLedIn};
  end

  // Strap capture: the first edge after reset release takes the pins, then the
  // values freeze. Pins are undriven in that cycle, so only the pull resistors count.
  always_comb begin
    next_phase = phase;
    next_portPolaritySwap = portPolaritySwap;
    next_gangPowerMode = gangPowerMode;
    next_phyDriveLevelField = phyDriveLevelField;
    next_activeLow = activeLow;
    case (phase)
      LSP_SAMPLE: begin
        next_phase = LSP_RUN;
        // Unstrapped lamps default to active low.
        next_activeLow = {LSP_NPIN{LSP_ACTLOW_DFLT}};
        if (swapStrapEnable) begin
          next_portPolaritySwap = portPrimaryLedIn;
          // A zero gives normal pairs and active high, a one the reverse.
          next_activeLow[LSP_PIN_PRI +: LSP_NPRI] = portPrimaryLedIn;
        end else begin
          next_portPolaritySwap = LSP_SWAP_DFLT;
        end
        if (gangStrapEnable) begin
          next_gangPowerMode = port3SecondaryLedIn;
          next_activeLow[LSP_PIN_P3] = port3SecondaryLedIn;
        end else begin
          next_gangPowerMode = LSP_GANG_DFLT;
        end
        if (boostStrapEnable) begin
          next_phyDriveLevelField = lowPortSecondaryLedIn;
          next_activeLow[LSP_PIN_LOW +: 2] = lowPortSecondaryLedIn;
        end else begin
          next_phyDriveLevelField = LSP_BOOST_DFLT;
        end
      end
      LSP_RUN: begin
        next_phase = LSP_RUN;
      end
      default: begin
        next_phase = LSP_SAMPLE;
      end
    endcase
  end

  // Strap flops; nothing but reset moves them once running.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= LSP_SAMPLE;
      portPolaritySwap <= LSP_SWAP_DFLT;
      gangPowerMode <= LSP_GANG_DFLT;
      phyDriveLevelField <= LSP_BOOST_DFLT;
      activeLow <= {LSP_NPIN{LSP_ACTLOW_DFLT}};
    end else begin
      phase <= next_phase;
      portPolaritySwap <= next_portPolaritySwap;
      gangPowerMode <= next_gangPowerMode;
      phyDriveLevelField <= next_phyDriveLevelField;
      activeLow <= next_activeLow;
    end
  end

  // A transfer is taken when selected, the bus is ready and it is NONSEQ; IDLE, BUSY and SEQ are ignored.
  always_comb begin
    addrPhase = hsel & hready & (htrans == LSP_HTRANS_NONSEQ);
  end

  // Views of the writable registers with a write in its data phase folded in,
  // so that a read straight after a write sees the new value.
  always_comb begin
    ctrlView = 32'h0000_0000;
    ctrlView[LSP_CTRL_LEDEN] = ledEnable;
    ledOnView = {18'h00000, ledOn};
    if (wrPending && wrAddr == LSP_CTRL_OFF) begin
      ctrlView[LSP_CTRL_LEDEN] = hwdata[LSP_CTRL_LEDEN];
    end
    if (wrPending && wrAddr == LSP_LEDON_OFF) begin
      ledOnView = {18'h00000, hwdata[13:0]};
    end
  end

  // Bus next values: writes land in their data phase, read data is loaded at the
  // address phase so hrdata comes from a flop with no wait state.
  always_comb begin
    next_wrPending = 1'b0;
    next_wrAddr = wrAddr;
    next_ledEnable = ledEnable;
    next_ledOn = ledOn;
    next_hrdata = hrdata;
    if (wrPending) begin
      if (wrAddr == LSP_CTRL_OFF) begin
        next_ledEnable = hwdata[LSP_CTRL_LEDEN];
      end else if (wrAddr == LSP_LEDON_OFF) begin
        next_ledOn = hwdata[13:0];
      end
    end
    if (addrPhase) begin
      next_wrPending = hwrite;
      next_wrAddr = {haddr[7:2], 2'b00};
      next_hrdata = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr[31:8] != 24'h000000) begin
          next_hrdata = 32'h0000_0000;
        end else if ({haddr[7:2], 2'b00} == LSP_CTRL_OFF) begin
          next_hrdata = ctrlView;
        end else if ({haddr[7:2], 2'b00} == LSP_LEDON_OFF) begin
          next_hrdata = ledOnView;
        end else if ({haddr[7:2], 2'b00} == LSP_STRAP_OFF) begin
          next_hrdata[LSP_ST_SWAP +: 7] = portPolaritySwap;
          next_hrdata[LSP_ST_GANG] = gangPowerMode;
          next_hrdata[LSP_ST_BOOST +: 2] = phyDriveLevelField;
          next_hrdata[LSP_ST_DONE] = (phase == LSP_RUN);
        end else if ({haddr[7:2], 2'b00} == LSP_PININ_OFF) begin
          next_hrdata = {18'h00000, pinIn};
        end else begin
          next_hrdata = 32'h0000_0000;
        end
      end
      // Writes with any of haddr[31:8] set are dropped here, before their data phase.
      if (haddr[31:8] != 24'h000000) begin
        next_wrPending = 1'b0;
      end
    end
  end

  // Bus and software register flops. The slave never stalls and always answers OKAY.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPending <= 1'b0;
      wrAddr <= 8'h00;
      ledEnable <= LSP_CTRL_RST;
      ledOn <= LSP_LEDON_RST;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= LSP_HRESP_OKAY;
    end else begin
      wrPending <= next_wrPending;
      wrAddr <= next_wrAddr;
      ledEnable <= next_ledEnable;
      ledOn <= next_ledOn;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= LSP_HRESP_OKAY;
    end
  end

  // Hand lamp state and polarity to the pin driver.
  always_comb begin
    pins.run = (phase == LSP_RUN);
    pins.ledEnable = ledEnable;
    pins.ledOn = ledOn;
    pins.activeLow = activeLow;
  end

  lsp_pin_drive u_drive (
    .clk(clk),
    .rst_n(rst_n),
    .pins(pins)
  );

  // Fan the registered pin drive back out to the pin groups.
  // Secondary lamps of ports four to seven stay active low in every case.
  always_comb begin
    portPrimaryLedOut = pins.pinOut[LSP_PIN_PRI +: LSP_NPRI];
    portPrimaryLedOe = pins.pinOe[LSP_PIN_PRI +: LSP_NPRI];
    lowPortSecondaryLedOut = pins.pinOut[LSP_PIN_LOW +: 2];
    lowPortSecondaryLedOe = pins.pinOe[LSP_PIN_LOW +: 2];
    port3SecondaryLedOut = pins.pinOut[LSP_PIN_P3];
    port3SecondaryLedOe = pins.pinOe[LSP_PIN_P3];
    upperPortSecondaryLedOut = pins.pinOut[LSP_PIN_UP +: 4];
    upperPortSecondaryLedOe = pins.pinOe[LSP_PIN_UP +: 4];
  end
endmodule : led_strap_pin_logic
`default_nettype wire

// file: testbench/lsp_checker.sv
`default_nettype none
module lsp_checker (
  // Clock, reset and bus answer.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  // Strap enables and pin levels.
  input wire logic swapStrapEnable,
  input wire logic gangStrapEnable,
  input wire logic boostStrapEnable,
  input wire logic [6:0] portPrimaryLedIn,
  input wire logic port3SecondaryLedIn,
  input wire logic [1:0] lowPortSecondaryLedIn,
  // Drive enables and strap results.
  input wire logic [6:0] portPrimaryLedOe,
  input wire logic [3:0] upperPortSecondaryLedOe,
  input wire logic port3SecondaryLedOe,
  input wire logic [1:0] lowPortSecondaryLedOe,
  input wire logic [6:0] portPolaritySwap,
  input wire logic gangPowerMode,
  input wire logic [1:0] phyDriveLevelField
);
  timeunit 1ns;
  timeprecision 1ps;
  logic started;
  logic [13:0] oeAll;
  // All drive enables in one vector.
  assign oeAll = {upperPortSecondaryLedOe, port3SecondaryLedOe, lowPortSecondaryLedOe,
    portPrimaryLedOe};
  // Low only up to the capture edge, which tells that edge apart from later ones.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_swap_capture: assert property (!started |=>
    portPolaritySwap == ($past(swapStrapEnable) ? $past(portPrimaryLedIn) : 7'h00))
    else $error("swap strap not captured");
  a_gang_capture: assert property (!started |=>
    gangPowerMode == ($past(gangStrapEnable) ? $past(port3SecondaryLedIn) : 1'b0))
    else $error("gang strap not captured");
  a_boost_capture: assert property (!started |=>
    phyDriveLevelField == ($past(boostStrapEnable) ? $past(lowPortSecondaryLedIn) : 2'h0))
    else $error("drive field not captured");
  // The capture edge itself moves the results, so hold is checked only from the second edge after it.
  a_strap_hold: assert property (started && $past(started) |->
    $stable({portPolaritySwap, gangPowerMode, phyDriveLevelField}))
    else $error("strap result changed");
  a_no_early_drive: assert property (!started |-> oeAll == 14'h0000)
    else $error("pin driven during capture");
  a_oe_after_capture: assert property ($rose(oeAll[0]) |-> $past(started))
    else $error("drive began too early");
  a_oe_together: assert property (oeAll == 14'h0000 || oeAll == 14'h3fff)
    else $error("lamp pins not driven together");
  a_bus_okay: assert property (hreadyout && hresp == 1'b0)
    else $error("bus answer not ready and okay");
endmodule : lsp_checker
bind led_strap_pin_logic lsp_checker chk (.clk, .rst_n, .hreadyout, .hresp,
  .swapStrapEnable, .gangStrapEnable, .boostStrapEnable, .portPrimaryLedIn,
  .port3SecondaryLedIn, .lowPortSecondaryLedIn, .portPrimaryLedOe,
  .upperPortSecondaryLedOe, .port3SecondaryLedOe, .lowPortSecondaryLedOe,
  .portPolaritySwap, .gangPowerMode, .phyDriveLevelField);
`default_nettype wire

// file: testbench/lsp_board_model.sv
`default_nettype none
module lsp_board_model (
  // Strap resistor levels.
  input wire logic [13:0] pull,
  // Device drive.
  input wire logic [13:0] drive,
  input wire logic [13:0] oe,
  // Pin levels.
  output logic [13:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin falls to its resistor, so no stale lamp level survives release.
  assign level = (oe & drive) | (~oe & pull);
endmodule : lsp_board_model
`default_nettype wire

// file: testbench/led_strap_pin_logic_test.sv
`default_nettype none
module led_strap_pin_logic_test
  import lsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] en; logic [13:0] pull; logic [10:0] st;} lsp_row_s;
  // Enables are boost, gang, swap; st is done, field, gang, swap.
  lsp_row_s rows [6] = '{'{3'h0, 14'h3fff, 11'h400}, '{3'h7, 14'h0000, 11'h400},
    '{3'h7, 14'h3fff, 11'h7ff}, '{3'h7, 14'h0155, 11'h655},
    '{3'h5, 14'h02aa, 11'h52a}, '{3'h2, 14'h3fff, 11'h480}};
  logic clk, rst_n, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize, en;
  logic [31:0] haddr, hwdata, rd;
  logic [13:0] pull, low, on;
  wire logic [31:0] hrdata;
  wire logic hreadyout, gang, resp;
  wire logic [13:0] out, oe, pin;
  wire logic [6:0] swap;
  wire logic [1:0] fld;
  int error_cnt = 0;
  int comparisons = 0;
  led_strap_pin_logic uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(resp), .swapStrapEnable(en[0]),
    .gangStrapEnable(en[1]), .boostStrapEnable(en[2]), .portPrimaryLedIn(pin[6:0]),
    .portPrimaryLedOut(out[6:0]), .portPrimaryLedOe(oe[6:0]),
    .upperPortSecondaryLedIn(pin[13:10]), .upperPortSecondaryLedOut(out[13:10]),
    .upperPortSecondaryLedOe(oe[13:10]), .port3SecondaryLedIn(pin[9]),
    .port3SecondaryLedOut(out[9]), .port3SecondaryLedOe(oe[9]),
    .lowPortSecondaryLedIn(pin[8:7]), .lowPortSecondaryLedOut(out[8:7]),
    .lowPortSecondaryLedOe(oe[8:7]), .portPolaritySwap(swap), .gangPowerMode(gang),
    .phyDriveLevelField(fld));
  lsp_board_model board (.pull(pull), .drive(out), .oe(oe), .level(pin));
  // Free-running bench clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One single word transfer; waits on hready, since the latency is the slave's call.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    htrans <= LSP_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic do_reset(input logic [2:0] e, input logic [13:0] p);
    rst_n <= 1'b0;
    en <= e;
    pull <= p;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset
  task automatic final_report;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  // Each row resets with new straps, then drives every lamp both ways.
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, en, pull} = '0;
    hsize = 3'h2;
    hsel = 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      do_reset(rows[i].en, rows[i].pull);
      check(32'({fld, gang, swap}), 32'(rows[i].st[9:0]));
      bus(1'b0, LSP_STRAP_OFF, 32'h0, rd);
      check(rd, 32'(rows[i].st));
      check(32'({hreadyout, resp}), 32'({1'b1, LSP_HRESP_OKAY}));
      low = 14'h3fff;
      if (rows[i].en[0]) low[6:0] = rows[i].pull[6:0];
      if (rows[i].en[2]) low[8:7] = rows[i].pull[8:7];
      if (rows[i].en[1]) low[9] = rows[i].pull[9];
      bus(1'b1, LSP_CTRL_OFF, 32'h1, rd);
      for (int k = 0; k < 2; k++) begin
        on = k ? 14'h2aaa : 14'h1555;
        bus(1'b1, LSP_LEDON_OFF, 32'(on), rd);
        repeat (2) @(posedge clk);
        check(32'(out), 32'(on ^ low));
        check(32'(oe), 32'h3fff);
        bus(1'b0, LSP_PININ_OFF, 32'h0, rd);
        check(rd, 32'(on ^ low));
      end
      check(32'({fld, gang, swap}), 32'(rows[i].st[9:0]));
    end
    bus(1'b1, LSP_STRAP_OFF, 32'h0, rd);
    bus(1'b0, LSP_STRAP_OFF, 32'h0, rd);
    check(rd, 32'h0000_0480);
    bus(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, LSP_CTRL_OFF, 32'h0, rd);
    repeat (2) @(posedge clk);
    check(32'(pin), 32'h3fff);
    final_report();
  end
endmodule : led_strap_pin_logic_test
`default_nettype wire
